// ==== logic/ccp_pkg.sv ====
// Package: constants, register map and mode decoding for the capture/compare/PWM channel
package ccp_pkg;

	// Register byte offsets
	localparam logic [11:0] ccp_off_control = 12'h000;
	localparam logic [11:0] ccp_off_low     = 12'h004;
	localparam logic [11:0] ccp_off_high    = 12'h008;
	localparam logic [11:0] ccp_off_status  = 12'h00c;
	localparam logic [11:0] ccp_off_config  = 12'h010;

	// Field positions
	localparam int ccp_pos_duty_low = 4;
	localparam int ccp_pos_flag     = 0;
	localparam int ccp_pos_dir      = 0;

	// Reset values
	localparam logic [3:0] ccp_rst_mode = 4'h0;
	localparam logic       ccp_rst_dir  = 1'b1;

	// Mode field codes
	localparam logic [3:0] ccp_mode_off      = 4'h0;
	localparam logic [3:0] ccp_mode_toggle   = 4'h2;
	localparam logic [3:0] ccp_mode_cap_fall = 4'h4;
	localparam logic [3:0] ccp_mode_cap_rise = 4'h5;
	localparam logic [3:0] ccp_mode_cap_4    = 4'h6;
	localparam logic [3:0] ccp_mode_cap_16   = 4'h7;
	localparam logic [3:0] ccp_mode_set_hi   = 4'h8;
	localparam logic [3:0] ccp_mode_set_lo   = 4'h9;
	localparam logic [3:0] ccp_mode_soft     = 4'ha;
	localparam logic [3:0] ccp_mode_special  = 4'hb;

	// Prescaler terminal counts
	localparam logic [3:0] ccp_presc_4  = 4'h3;
	localparam logic [3:0] ccp_presc_16 = 4'hf;

	function automatic logic ccp_is_capture(input logic [3:0] mode);
		return mode[3:2] == 2'b01;
	endfunction : ccp_is_capture

	function automatic logic ccp_is_compare(input logic [3:0] mode);
		return (mode == ccp_mode_toggle) || (mode[3:2] == 2'b10);
	endfunction : ccp_is_compare

	function automatic logic ccp_is_pwm(input logic [3:0] mode);
		return mode[3:2] == 2'b11;
	endfunction : ccp_is_pwm

	function automatic logic ccp_drives_pin(input logic [3:0] mode);
		return ccp_is_pwm(mode) || mode == ccp_mode_toggle || mode == ccp_mode_set_hi
			|| mode == ccp_mode_set_lo;
	endfunction : ccp_drives_pin

endpackage : ccp_pkg

// ==== logic/ccp_evt_if.sv ====
// Interface: pin edge pulses and capture events between channel submodules
`timescale 1ns/1ps
`default_nettype none
interface ccp_evt_if;
	logic rise;
	logic fall;
	logic capture;
	modport sync_end (output rise, output fall);
	modport presc_end (input rise, input fall, output capture);
	modport core_end (input capture);
endinterface : ccp_evt_if
`default_nettype wire

// ==== logic/ccp_pin_sync.sv ====
// Pin synchroniser with agreement filter and edge detector
`timescale 1ns/1ps
`default_nettype none
module ccp_pin_sync (
	// Clock and reset
	input  wire logic     pclk,
	input  wire logic     presetn,
	// Pin and edges
	input  wire logic     pin_in,
	ccp_evt_if.sync_end   evt
);

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic level;
		logic rise;
		logic fall;
	} ccp_sync_type;

	ccp_sync_type r;
	ccp_sync_type next_r;

	always_comb begin
		next_r       = r;
		next_r.s1    = pin_in;
		next_r.s2    = r.s1;
		next_r.s3    = r.s2;
		next_r.rise  = 1'b0;
		next_r.fall  = 1'b0;
		// Level moves only once two stages agree, so one metastable sample cannot make an edge
		if (r.s2 == r.s3 && r.s3 != r.level) begin
			next_r.level = r.s3;
			next_r.rise  = r.s3;
			next_r.fall  = !r.s3;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign evt.rise = r.rise;
	assign evt.fall = r.fall;

	edge_agree_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.rise |-> $past(r.s2) && $past(r.s3) && !$past(r.level))
		else $error("rise without agreeing samples");

endmodule : ccp_pin_sync
`default_nettype wire

// ==== logic/ccp_capture_presc.sv ====
// Capture event selection and edge prescaler
`timescale 1ns/1ps
`default_nettype none
module ccp_capture_presc (
	// Clock and reset
	input  wire logic       pclk,
	input  wire logic       presetn,
	// Mode
	input  wire logic [3:0] mode,
	// Events
	ccp_evt_if.presc_end    evt
);

	typedef struct packed {
		logic [3:0] count;
		logic       capture;
	} ccp_presc_type;

	ccp_presc_type r;
	ccp_presc_type next_r;

	always_comb begin
		next_r         = r;
		next_r.capture = 1'b0;
		if (!ccp_pkg::ccp_is_capture(mode)) begin
			next_r.count = 4'h0;
		end else begin
			// Mode changes among capture settings keep the count running
			unique case (mode)
				ccp_pkg::ccp_mode_cap_fall: next_r.capture = evt.fall;
				ccp_pkg::ccp_mode_cap_rise: next_r.capture = evt.rise;
				ccp_pkg::ccp_mode_cap_4: begin
					next_r.capture = evt.rise && r.count[1:0] == ccp_pkg::ccp_presc_4[1:0];
				end
				ccp_pkg::ccp_mode_cap_16: begin
					next_r.capture = evt.rise && r.count == ccp_pkg::ccp_presc_16;
				end
				default: next_r.capture = 1'b0;
			endcase
			if (evt.rise && mode[1]) begin
				next_r.count = r.count + 4'h1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	assign evt.capture = r.capture;

	presc_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		!ccp_pkg::ccp_is_capture(mode) |=> r.count == 4'h0)
		else $error("prescaler not cleared outside capture");

	presc_16_a: assert property (@(posedge pclk) disable iff (!presetn)
		mode == ccp_pkg::ccp_mode_cap_16 && evt.rise && r.count != 4'hf |=> !r.capture)
		else $error("early capture in divide by 16");

endmodule : ccp_capture_presc
`default_nettype wire

// ==== logic/ccp_unit.sv ====
// Capture/compare/PWM channel top with APB register slave
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module ccp_unit (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Capture/compare timer from the assignment block
	input  wire logic [15:0] timer_count,
	output logic             timer_clear,
	// PWM period timer from the assignment block
	input  wire logic [7:0]  pwm_period_timer,
	input  wire logic [1:0]  pwm_sub_count,
	input  wire logic        pwm_tick,
	input  wire logic [7:0]  pwm_period_limit,
	output logic             pwm_timer_clear,
	// Channel pin
	input  wire logic        channel_pin_in,
	output logic             channel_pin_out,
	output logic             channel_pin_oe_n,
	// Status
	output logic             channel_irq_flag
);

	typedef struct packed {
		logic [3:0]  mode;
		logic [1:0]  duty_low_bits;
		logic [7:0]  data_low;
		logic [7:0]  data_high;
		logic [1:0]  duty_latch;
		logic        dir_input;
		logic        flag;
		logic        pin;
		logic        oe_n;
		logic        match_prev;
		logic        timer_clear;
		logic        pwm_clear;
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} ccp_state_type;

	ccp_state_type r;
	ccp_state_type next_r;

	ccp_evt_if evt ();

	// Pin is sampled whatever the direction, so port writes can capture
	ccp_pin_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.pin_in  (channel_pin_in),
		.evt     (evt.sync_end)
	);

	ccp_capture_presc u_presc (
		.pclk    (pclk),
		.presetn (presetn),
		.mode    (r.mode),
		.evt     (evt.presc_end)
	);

	logic        setup;
	logic        wr;
	logic        off_wr;
	logic        mapped;
	logic        cmp_hit;
	logic        pwm_end;
	logic        pwm_off;
	logic [15:0] cmp_value;

	always_comb begin
		setup     = psel && !penable;
		wr        = psel && penable && pwrite && r.pready;
		off_wr    = wr && paddr == ccp_pkg::ccp_off_control
			&& pwdata[3:0] == ccp_pkg::ccp_mode_off;
		mapped    = paddr == ccp_pkg::ccp_off_control || paddr == ccp_pkg::ccp_off_low
			|| paddr == ccp_pkg::ccp_off_high || paddr == ccp_pkg::ccp_off_status
			|| paddr == ccp_pkg::ccp_off_config;
		cmp_value = {r.data_high, r.data_low};
		// Only the first cycle of equality acts, the timer may hold a value many clocks
		cmp_hit   = ccp_pkg::ccp_is_compare(r.mode) && timer_count == cmp_value
			&& !r.match_prev;
		pwm_end   = ccp_pkg::ccp_is_pwm(r.mode) && pwm_tick
			&& pwm_period_timer == pwm_period_limit;
		pwm_off   = {r.data_high, r.duty_latch} == {pwm_period_timer, pwm_sub_count};
	end

	always_comb begin
		next_r             = r;
		next_r.timer_clear = 1'b0;
		next_r.pwm_clear   = 1'b0;
		next_r.pready      = 1'b0;
		next_r.pslverr     = 1'b0;
		next_r.match_prev  = ccp_pkg::ccp_is_compare(r.mode) && timer_count == cmp_value;

		// APB setup cycle: fetch read data, answer in the access cycle
		if (setup) begin
			next_r.pready  = 1'b1;
			next_r.pslverr = !mapped;
			next_r.prdata  = 32'h0000_0000;
			unique case (paddr)
				ccp_pkg::ccp_off_control: next_r.prdata = {26'h0, r.duty_low_bits, r.mode};
				ccp_pkg::ccp_off_low:     next_r.prdata = {24'h0, r.data_low};
				ccp_pkg::ccp_off_high:    next_r.prdata = {24'h0, r.data_high};
				ccp_pkg::ccp_off_status:  next_r.prdata = {31'h0, r.flag};
				ccp_pkg::ccp_off_config:  next_r.prdata = {31'h0, r.dir_input};
				default:                  next_r.prdata = 32'h0000_0000;
			endcase
		end

		// APB writes
		if (wr) begin
			unique case (paddr)
				ccp_pkg::ccp_off_control: begin
					next_r.mode          = pwdata[3:0];
					next_r.duty_low_bits = pwdata[ccp_pkg::ccp_pos_duty_low +: 2];
					if (pwdata[3:0] == ccp_pkg::ccp_mode_off) begin
						next_r.pin = 1'b0;
					end else if (pwdata[3:0] != r.mode) begin
						if (pwdata[3:0] == ccp_pkg::ccp_mode_set_hi) begin
							next_r.pin = 1'b0;
						end else if (pwdata[3:0] == ccp_pkg::ccp_mode_set_lo) begin
							next_r.pin = 1'b1;
						end
					end
				end
				ccp_pkg::ccp_off_low: next_r.data_low = pwdata[7:0];
				ccp_pkg::ccp_off_high: begin
					if (!ccp_pkg::ccp_is_pwm(r.mode)) begin
						next_r.data_high = pwdata[7:0];
					end
				end
				ccp_pkg::ccp_off_status: begin
					if (pwdata[ccp_pkg::ccp_pos_flag]) begin
						next_r.flag = 1'b0;
					end
				end
				ccp_pkg::ccp_off_config: next_r.dir_input = pwdata[ccp_pkg::ccp_pos_dir];
				default: next_r.flag = next_r.flag;
			endcase
		end

		// Capture: hardware set wins over a clearing write in the same cycle
		if (ccp_pkg::ccp_is_capture(r.mode) && evt.capture) begin
			next_r.data_high = timer_count[15:8];
			next_r.data_low  = timer_count[7:0];
			next_r.flag      = 1'b1;
		end

		// Compare actions
		if (cmp_hit) begin
			next_r.flag = 1'b1;
			unique case (r.mode)
				ccp_pkg::ccp_mode_toggle:  next_r.pin = !r.pin;
				ccp_pkg::ccp_mode_set_hi:  next_r.pin = 1'b1;
				ccp_pkg::ccp_mode_set_lo:  next_r.pin = 1'b0;
				// Special event only clears the timer; no converter start exists here
				ccp_pkg::ccp_mode_special: next_r.timer_clear = 1'b1;
				default:                   next_r.pin = r.pin;
			endcase
		end

		// PWM: boundary takes priority over the duty match
		if (pwm_end) begin
			next_r.pwm_clear  = 1'b1;
			next_r.data_high  = r.data_low;
			next_r.duty_latch = r.duty_low_bits;
			next_r.pin        = {r.data_low, r.duty_low_bits} != 10'h000;
		end else if (ccp_pkg::ccp_is_pwm(r.mode) && pwm_off) begin
			// Duty beyond the period never matches, so the pin stays high
			next_r.pin = 1'b0;
		end

		// Disable write beats a match or period boundary of the old mode in the same cycle
		if (off_wr) begin
			next_r.pin = 1'b0;
		end

		next_r.oe_n = next_r.dir_input || !ccp_pkg::ccp_drives_pin(next_r.mode);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			r           <= '0;
			r.mode      <= ccp_pkg::ccp_rst_mode;
			r.dir_input <= ccp_pkg::ccp_rst_dir;
			r.oe_n      <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	assign prdata           = r.prdata;
	assign pready           = r.pready;
	assign pslverr          = r.pslverr;
	assign timer_clear      = r.timer_clear;
	assign pwm_timer_clear  = r.pwm_clear;
	assign channel_pin_out  = r.pin;
	assign channel_pin_oe_n = r.oe_n;
	assign channel_irq_flag = r.flag;

	cap_copy_a: assert property (@(posedge pclk) disable iff (!presetn)
		ccp_pkg::ccp_is_capture(r.mode) && evt.capture
		|=> {r.data_high, r.data_low} == $past(timer_count) && r.flag)
		else $error("capture did not copy timer");

	flag_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.flag && !(wr && paddr == ccp_pkg::ccp_off_status && pwdata[0]) |=> r.flag)
		else $error("flag lost without software clear");

	cmp_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_hit && r.mode == ccp_pkg::ccp_mode_set_hi
		|=> ($past(off_wr) ? !r.pin : r.pin) && r.flag)
		else $error("set-high match did not act");

	soft_mode_a: assert property (@(posedge pclk) disable iff (!presetn)
		r.mode == ccp_pkg::ccp_mode_soft |-> r.oe_n)
		else $error("software compare mode drives pin");

	special_trig_a: assert property (@(posedge pclk) disable iff (!presetn)
		cmp_hit && r.mode == ccp_pkg::ccp_mode_special |=> timer_clear ##1 !timer_clear)
		else $error("special event timer clear missing");

	ctrl_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
		wr && paddr == ccp_pkg::ccp_off_control && pwdata[3:0] == 4'h0 |=> !r.pin)
		else $error("output latch not forced low");

	pwm_bound_a: assert property (@(posedge pclk) disable iff (!presetn)
		pwm_end |=> pwm_timer_clear && r.data_high == $past(r.data_low)
		&& r.pin == (!$past(off_wr) && $past({r.data_low, r.duty_low_bits}) != 10'h000))
		else $error("period boundary actions wrong");

	pwm_duty_a: assert property (@(posedge pclk) disable iff (!presetn)
		ccp_pkg::ccp_is_pwm(r.mode) && !pwm_end && pwm_off |=> !r.pin)
		else $error("duty match did not clear pin");

	duty_ro_a: assert property (@(posedge pclk) disable iff (!presetn)
		ccp_pkg::ccp_is_pwm(r.mode) && !pwm_end |=> r.data_high == $past(r.data_high))
		else $error("duty buffer changed mid period");

endmodule : ccp_unit
`default_nettype wire

// ==== sim/ccp_far_model.sv ====
// Far-side model: assigned capture/compare timer and PWM period timer
`timescale 1ns/1ps
`default_nettype none
module ccp_far_model (
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// Bench control
	input  wire logic        run,
	input  wire logic        load,
	input  wire logic [15:0] load_val,
	input  wire logic [7:0]  limit,
	// Requests from the channel
	input  wire logic        timer_clear,
	input  wire logic        pwm_timer_clear,
	// Timer values
	output logic      [15:0] timer_count,
	output logic      [7:0]  pwm_period_timer,
	output logic      [1:0]  pwm_sub_count,
	output logic             pwm_tick
);
	// Tick on the last sub-count, so one timer step is 4 clocks
	assign pwm_tick = (pwm_sub_count == 2'h3);
	// Same clock as the channel: no asynchronous counting
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_count <= 16'h0000;
			pwm_period_timer <= 8'h00;
			pwm_sub_count <= 2'h0;
		end else begin
			if (load)
				timer_count <= load_val;
			else if (timer_clear)
				timer_count <= 16'h0000;
			else if (run)
				timer_count <= timer_count + 16'h0001;
			pwm_sub_count <= pwm_sub_count + 2'h1;
			// Timer wraps by itself; the late clear request is harmless
			if (pwm_tick && pwm_period_timer == limit)
				pwm_period_timer <= 8'h00;
			else if (pwm_timer_clear)
				pwm_period_timer <= 8'h00;
			else if (pwm_tick)
				pwm_period_timer <= pwm_period_timer + 8'h01;
		end
	end
endmodule : ccp_far_model
`default_nettype wire

// ==== sim/tb_top.sv ====
// Testbench: register-level tests of the capture/compare/PWM channel
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb_top;
	localparam logic [11:0] a_ctl = ccp_pkg::ccp_off_control;
	localparam logic [11:0] a_low = ccp_pkg::ccp_off_low;
	localparam logic [11:0] a_hi  = ccp_pkg::ccp_off_high;
	localparam logic [11:0] a_st  = ccp_pkg::ccp_off_status;
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [15:0] timer_count, load_val, v;
	logic [7:0]  pwm_period_timer, limit;
	logic [1:0]  pwm_sub_count;
	logic        pwm_tick, timer_clear, pwm_timer_clear, run, load, pin_drv, e, s;
	logic        channel_pin_in, channel_pin_out, channel_pin_oe_n, channel_irq_flag;
	logic [3:0]  cm [5] = '{4'h2, 4'h8, 4'h9, 4'ha, 4'hb};
	logic        ini [5] = '{1'b0, 1'b0, 1'b1, 1'b0, 1'b0};
	logic        fin [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0};
	logic        oen [5] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b1};
	int          num_errors, n_compared, n, h1, h2, p;
	// Pin level: the channel drives it when enabled, else the outside world
	assign channel_pin_in = channel_pin_oe_n ? pin_drv : channel_pin_out;
	ccp_unit u_ccp_unit (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .timer_count(timer_count),
		.timer_clear(timer_clear), .pwm_period_timer(pwm_period_timer),
		.pwm_sub_count(pwm_sub_count), .pwm_tick(pwm_tick), .pwm_period_limit(limit),
		.pwm_timer_clear(pwm_timer_clear), .channel_pin_in(channel_pin_in),
		.channel_pin_out(channel_pin_out), .channel_pin_oe_n(channel_pin_oe_n),
		.channel_irq_flag(channel_irq_flag));
	ccp_far_model u_ccp_far_model (.pclk(pclk), .presetn(presetn), .run(run), .load(load),
		.load_val(load_val), .limit(limit), .timer_clear(timer_clear),
		.pwm_timer_clear(pwm_timer_clear), .timer_count(timer_count),
		.pwm_period_timer(pwm_period_timer), .pwm_sub_count(pwm_sub_count),
		.pwm_tick(pwm_tick));
	task automatic print_verdict();
		$display("errors %0d compared %0d", num_errors, n_compared);
		if (num_errors == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : print_verdict
	task automatic hang();
		num_errors++;
		print_verdict();
	endtask : hang
	// One APB transfer; ends one edge after release so results have landed
	task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d,
		output logic [31:0] rd, output logic er);
		int k;
		psel <= 1'b1;
		penable <= 1'b0;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do begin
			@(posedge pclk);
			k++;
		end while (pready !== 1'b1 && k < 16);
		if (k >= 16)
			hang();
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask : xfer
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] x;
		logic        y;
		xfer(a, 1'b1, d, x, y);
	endtask : wr
	task automatic rd(input logic [11:0] a, output logic [31:0] d);
		logic y;
		xfer(a, 1'b0, 32'h0, d, y);
	endtask : rd
	task automatic mode(input logic [3:0] m);
		wr(a_ctl, {28'h0000000, m});
	endtask : mode
	task automatic set_timer(input logic [15:0] t);
		@(posedge pclk);
		load <= 1'b1;
		load_val <= t;
		@(posedge pclk);
		load <= 1'b0;
	endtask : set_timer
	// Pin moves, then time for the synchroniser and capture to settle
	task automatic pin_edge(input logic l);
		@(posedge pclk);
		pin_drv <= l;
		repeat (10) @(posedge pclk);
	endtask : pin_edge
	task automatic rises(input int c);
		for (int i = 0; i < c; i++) begin
			pin_edge(1'b1);
			pin_edge(1'b0);
		end
	endtask : rises
	// Bounded wait on flag (w=0) or pin output (w=1)
	task automatic wait_on(input logic w, input logic l, output int c);
		c = 0;
		do begin
			@(posedge pclk);
			c++;
		end while ((w ? channel_pin_out : channel_irq_flag) !== l && c < 400);
		if (c >= 400)
			hang();
	endtask : wait_on
	task automatic cap_val(output logic [15:0] t);
		logic [31:0] lo, hi;
		rd(a_low, lo);
		rd(a_hi, hi);
		t = {hi[7:0], lo[7:0]};
	endtask : cap_val
	task automatic measure(output int hi, output int per);
		int lo;
		wait_on(1'b1, 1'b0, lo);
		wait_on(1'b1, 1'b1, lo);
		wait_on(1'b1, 1'b0, hi);
		wait_on(1'b1, 1'b1, lo);
		per = hi + lo;
	endtask : measure
	// Also counts period clear requests: exactly two in any 40 clocks at limit 4
	task automatic watch(input logic l, output logic seen, output int clr);
		seen = 1'b0;
		clr = 0;
		repeat (40) @(posedge pclk);
		repeat (40) begin
			@(posedge pclk);
			seen = seen | (channel_pin_out === l);
			clr += (pwm_timer_clear === 1'b1);
		end
	endtask : watch
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		{run, load, load_val, pin_drv, num_errors, n_compared} = '0;
		limit = 8'h04;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(a_ctl, r);
		`CHK(r, 32'h0)
		rd(ccp_pkg::ccp_off_config, r);
		`CHK(r, 32'h1)
		xfer(12'h020, 1'b0, 32'h0, r, e);
		`CHK({e, r}, 33'h100000000)
		// Capture on rise, then a second capture while the flag is still set
		mode(ccp_pkg::ccp_mode_cap_rise);
		set_timer(16'h1234);
		pin_edge(1'b1);
		wait_on(1'b0, 1'b1, n);
		cap_val(v);
		`CHK(v, 16'h1234)
		set_timer(16'hbeef);
		pin_edge(1'b0);
		`CHK(channel_irq_flag, 1'b1)
		pin_edge(1'b1);
		cap_val(v);
		`CHK(v, 16'hbeef)
		wr(a_st, 32'h1);
		rd(a_st, r);
		`CHK(r, 32'h0)
		mode(ccp_pkg::ccp_mode_cap_fall);
		wr(a_st, 32'h1);
		pin_edge(1'b0);
		`CHK(channel_irq_flag, 1'b1)
		wr(a_st, 32'h1);
		pin_edge(1'b1);
		`CHK(channel_irq_flag, 1'b0)
		pin_edge(1'b0);
		`CHK(channel_irq_flag, 1'b1)
		for (int k = 0; k < 2; k++) begin
			mode(ccp_pkg::ccp_mode_off);
			mode(k ? ccp_pkg::ccp_mode_cap_16 : ccp_pkg::ccp_mode_cap_4);
			wr(a_st, 32'h1);
			rises(k ? 15 : 3);
			`CHK(channel_irq_flag, 1'b0)
			rises(1);
			`CHK(channel_irq_flag, 1'b1)
		end
		// Disable between settings restarts the edge count
		mode(ccp_pkg::ccp_mode_off);
		mode(ccp_pkg::ccp_mode_cap_4);
		wr(a_st, 32'h1);
		rises(2);
		mode(ccp_pkg::ccp_mode_off);
		mode(ccp_pkg::ccp_mode_cap_4);
		rises(3);
		`CHK(channel_irq_flag, 1'b0)
		// Compare modes, pin as output
		wr(ccp_pkg::ccp_off_config, 32'h0);
		@(posedge pclk);
		run <= 1'b1;
		for (int i = 0; i < 5; i++) begin
			mode(ccp_pkg::ccp_mode_off);
			`CHK(channel_pin_out, 1'b0)
			set_timer(16'h0f00);
			wr(a_low, 32'h40);
			wr(a_hi, 32'h0f);
			mode(cm[i]);
			`CHK(channel_pin_out, ini[i])
			wr(a_st, 32'h1);
			wait_on(1'b0, 1'b1, n);
			repeat (2) @(posedge pclk);
			`CHK(channel_pin_out, fin[i])
			`CHK(channel_pin_oe_n, oen[i])
			if (i == 4)
				`CHK(timer_count < 16'h0010, 1'b1)
		end
		// PWM: duty 9 quarter-steps in a period of 5 timer steps
		wr(a_low, 32'h02);
		wr(a_ctl, 32'h1c);
		measure(h1, p);
		`CHK(p, (int'(limit) + 1) * 4)
		wr(a_low, 32'h03);
		rd(a_hi, r);
		`CHK(r, 32'h02)
		measure(h2, p);
		`CHK(h2 - h1, 4)
		rd(a_hi, r);
		`CHK(r, 32'h03)
		wr(a_hi, 32'h55);
		rd(a_hi, r);
		`CHK(r, 32'h03)
		wr(a_low, 32'h00);
		wr(a_ctl, 32'h0c);
		watch(1'b1, s, n);
		`CHK(s, 1'b0)
		`CHK(n, 2)
		wr(a_low, 32'h10);
		watch(1'b0, s, n);
		`CHK(s, 1'b0)
		`CHK(n, 2)
		mode(ccp_pkg::ccp_mode_off);
		`CHK(channel_pin_out, 1'b0)
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
